// *** common/xdec_params.svh ***
// Constants for the extended instruction decoder
`ifndef XDEC_PARAMS_SVH
`define XDEC_PARAMS_SVH
`define XDEC_OP_PTR_ADD     8'he8
`define XDEC_OP_PTR_SUB     8'he9
`define XDEC_OP_PUSH        8'hea
`define XDEC_OP_MOVS        8'heb
`define XDEC_OP_SECOND      4'hf
`define XDEC_OP_INDIRECT_CALL_WORKING_REG       16'h0014
`define XDEC_PTR_TWO        2'h3
`define XDEC_IDX_LIMIT      8'h5f
`define XDEC_RESET_INSTR    16'h0000
`endif

// *** common/xdec_pkg.sv ***
// Types for the extended instruction decoder
package xdec_pkg;
	typedef enum logic [3:0] {
		XDEC_BASE,
		XDEC_PTR_ADD,
		XDEC_PTR_SUB,
		XDEC_PTR2_ADD_RET,
		XDEC_PTR2_SUB_RET,
		XDEC_CALL_WORKING_REGISTER,
		XDEC_MOVE_TO_FILE,
		XDEC_MOVE_TO_INDEXED,
		XDEC_PUSH_LIT,
		XDEC_SECOND_WORD,
		XDEC_ILLEGAL
	} xdec_op_e;

	// Decoded instruction as handed to the data path
	typedef struct packed {
		xdec_op_e   op;
		logic [1:0] ptr_sel;
		logic [7:0] literal;
		logic [11:0] addr;
		logic       dest;
		logic       access;
		logic       indexed;
		logic [1:0] cycles;
		logic       valid;
	} xdec_dec_s;

	// Decoder state: last decode and second-word flag
	typedef struct packed {
		xdec_dec_s  dec;
		logic       second_pending;
	} xdec_state_s;
endpackage

// *** core/xdec_decoder.sv ***
// Instruction decoder with optional extended set
`timescale 1ns/1ps
`include "xdec_params.svh"

module xdec_decoder
	import xdec_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_fuse,
	input  wire logic        i_instr_valid,
	input  wire logic [15:0] i_instr,
	output xdec_dec_s        o_dec,
	output logic             o_ext_active
);

	logic        fuse_m_r;
	logic        fuse_r;
	logic        ext_r;
	xdec_state_s st_r;
	xdec_state_s st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Fuse synchroniser, two flops, then the ext_r stage that follows the fuse
	// fuse gates extension
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			fuse_m_r <= 1'b0;
			fuse_r   <= 1'b0;
			ext_r    <= 1'b0;
		end else begin
			fuse_m_r <= i_fuse;
			fuse_r   <= fuse_m_r;
			ext_r    <= fuse_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode
	always_comb begin
		st_nxt = st_r;
		st_nxt.dec.valid = 1'b0;
		if (i_instr_valid) begin
			st_nxt.dec.valid   = 1'b1;
			st_nxt.dec.op      = XDEC_BASE;
			st_nxt.dec.ptr_sel = i_instr[7:6];
			st_nxt.dec.literal = i_instr[7:0];
			st_nxt.dec.addr    = {4'h0, i_instr[7:0]};
			st_nxt.dec.dest    = i_instr[9];
			st_nxt.dec.access  = i_instr[8];
			st_nxt.dec.indexed = 1'b0;
			st_nxt.dec.cycles  = 2'h1;
			// eight extra opcodes decoded from here
			if (st_r.second_pending) begin
				// Second word of a two-word move
				st_nxt.second_pending = 1'b0;
				st_nxt.dec.op   = ext_r ? XDEC_SECOND_WORD : XDEC_ILLEGAL;
				st_nxt.dec.addr = i_instr[11:0];
			end else if (i_instr == `XDEC_OP_INDIRECT_CALL_WORKING_REG) begin
				st_nxt.dec.op     = ext_r ? XDEC_CALL_WORKING_REGISTER : XDEC_ILLEGAL;
				st_nxt.dec.cycles = 2'h2;
			end else if (i_instr[15:8] == `XDEC_OP_PTR_ADD
				|| i_instr[15:8] == `XDEC_OP_PTR_SUB) begin
				st_nxt.dec.literal = {2'h0, i_instr[5:0]};
				if (i_instr[7:6] == `XDEC_PTR_TWO) begin
					st_nxt.dec.op = i_instr[8] ? XDEC_PTR2_SUB_RET : XDEC_PTR2_ADD_RET;
					st_nxt.dec.cycles = 2'h2;
				end else begin
					st_nxt.dec.op = i_instr[8] ? XDEC_PTR_SUB : XDEC_PTR_ADD;
				end
				if (!ext_r) begin
					st_nxt.dec.op = XDEC_ILLEGAL;
				end
			end else if (i_instr[15:8] == `XDEC_OP_PUSH) begin
				st_nxt.dec.op      = ext_r ? XDEC_PUSH_LIT : XDEC_ILLEGAL;
				st_nxt.dec.ptr_sel = `XDEC_PTR_TWO;
			end else if (i_instr[15:8] == `XDEC_OP_MOVS) begin
				// memory moves take a second word
				st_nxt.dec.literal = {1'b0, i_instr[6:0]};
				st_nxt.dec.cycles  = 2'h2;
				st_nxt.dec.op      = i_instr[7] ? XDEC_MOVE_TO_INDEXED : XDEC_MOVE_TO_FILE;
				st_nxt.second_pending = ext_r;
				if (!ext_r) begin
					st_nxt.dec.op = XDEC_ILLEGAL;
				end
			end else begin
				// base set; indexed when a=0 and f low
				st_nxt.dec.indexed = ext_r && !i_instr[8]
					&& (i_instr[7:0] <= `XDEC_IDX_LIMIT)
					&& (i_instr[15:12] != 4'he) && (i_instr[15:12] != 4'hf)
					&& (i_instr[15:12] != 4'h0);
			end
		end
	end

	// State register, one update per clock
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Registered outputs
	assign o_dec        = st_r.dec;
	assign o_ext_active = ext_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_fuse_gates_ext: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_instr_valid && !ext_r && !st_r.second_pending && i_instr[15:8] == `XDEC_OP_PUSH)
		|=> o_dec.op == XDEC_ILLEGAL) else $error("extended op decoded with fuse clear");
	a_reset_inactive: assert property (@(posedge i_clk)
		i_reset |=> !o_ext_active && !o_dec.valid) else $error("extension active after reset");
	a_ptr2_two_cycles: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && (o_dec.op == XDEC_PTR2_ADD_RET || o_dec.op == XDEC_PTR2_SUB_RET)
		|-> o_dec.cycles == 2'h2 && o_dec.ptr_sel == 2'h3) else $error("bad pointer two op");
	a_add_one_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_PTR_ADD |-> o_dec.cycles == 2'h1
		&& o_dec.literal[7:6] == 2'h0) else $error("bad pointer add decode");
	a_call_decode: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_instr_valid && ext_r && !st_r.second_pending && i_instr == 16'h0014)
		|=> o_dec.op == XDEC_CALL_WORKING_REGISTER && o_dec.cycles == 2'h2) else $error("call missed");
	a_push_decode: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_PUSH_LIT |-> o_dec.cycles == 2'h1
		&& o_dec.ptr_sel == 2'h3 && $past(o_ext_active)) else $error("bad push decode");
	a_move_second: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_MOVE_TO_FILE && !i_instr_valid ##1 i_instr_valid
		&& o_ext_active |=> o_dec.op == XDEC_SECOND_WORD) else $error("move second word lost");
	a_base_kept: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_instr_valid && !st_r.second_pending && i_instr[15:12] == 4'h1)
		|=> o_dec.op == XDEC_BASE) else $error("base op not decoded");
	a_indexed_ext: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.indexed |-> $past(ext_r) && !o_dec.access
		&& o_dec.addr[7:0] <= 8'h5f) else $error("bad indexed mode");

	////////////////////////////////////////////////////////////////////////////
	// Fuse and handshake checks
	// Three clean samples of a set fuse turn the extension on
	a_fuse_sets_ext: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_fuse && !i_reset) [*3]
		|=> o_ext_active) else $error("extension not enabled by the fuse");
	// Three samples of a clear fuse keep it off
	a_fuse_clears_ext: assert property (@(posedge i_clk) disable iff (i_reset)
		(!i_fuse) [*3]
		|=> !o_ext_active) else $error("extension active with the fuse clear");
	// Every taken word yields one valid decode
	a_valid_follows: assert property (@(posedge i_clk) disable iff (i_reset)
		!i_reset
		|=> o_dec.valid == $past(i_instr_valid)) else $error("decode valid out of step");

	////////////////////////////////////////////////////////////////////////////
	// Decode checks
	// Operand fields taken from the word in the same places
	a_fields_common: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && !st_r.second_pending |=> o_dec.dest == $past(i_instr[9])
		&& o_dec.access == $past(i_instr[8])) else $error("operand field moved");
	// Plain pointer add decodes as add and keeps its six-bit literal
	a_add_decode: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && ext_r && !st_r.second_pending && i_instr[15:8] == `XDEC_OP_PTR_ADD
		&& i_instr[7:6] != `XDEC_PTR_TWO |=> o_dec.op == XDEC_PTR_ADD
		&& o_dec.literal == {2'h0, $past(i_instr[5:0])}) else $error("pointer add missed");
	// Pointer subtract is one cycle with a six-bit literal
	a_sub_one_cycle: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_PTR_SUB |-> o_dec.cycles == 2'h1
		&& o_dec.literal[7:6] == 2'h0) else $error("bad pointer subtract decode");
	// Plain pointer ops never name pointer two
	a_ptr_sel_plain: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && (o_dec.op == XDEC_PTR_ADD || o_dec.op == XDEC_PTR_SUB)
		|-> o_dec.ptr_sel != `XDEC_PTR_TWO) else $error("plain pointer op on pointer two");
	// Pointer field 11 on add selects the add-and-return form
	a_add_ret_decode: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && ext_r && !st_r.second_pending
		&& i_instr[15:6] == {`XDEC_OP_PTR_ADD, `XDEC_PTR_TWO}
		|=> o_dec.op == XDEC_PTR2_ADD_RET) else $error("add and return missed");
	// Pointer field 11 on subtract selects the subtract-and-return form
	a_sub_ret_decode: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && ext_r && !st_r.second_pending
		&& i_instr[15:6] == {`XDEC_OP_PTR_SUB, `XDEC_PTR_TWO}
		|=> o_dec.op == XDEC_PTR2_SUB_RET) else $error("subtract and return missed");
	// Indirect call only from its one fixed word
	a_call_fixed: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_CALL_WORKING_REGISTER
		|-> $past(i_instr) == `XDEC_OP_INDIRECT_CALL_WORKING_REG) else $error("call from wrong word");
	// Push keeps the whole eight-bit literal
	a_push_literal: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && ext_r && !st_r.second_pending && i_instr[15:8] == `XDEC_OP_PUSH
		|=> o_dec.op == XDEC_PUSH_LIT
		&& o_dec.literal == $past(i_instr[7:0])) else $error("push literal lost");
	// Memory moves take two cycles and a seven-bit source offset
	a_movs_literal: assert property (@(posedge i_clk) disable iff (i_reset)
		i_instr_valid && ext_r && !st_r.second_pending && i_instr[15:8] == `XDEC_OP_MOVS
		|=> o_dec.cycles == 2'h2
		&& o_dec.literal == {1'b0, $past(i_instr[6:0])}) else $error("move decode wrong");
	// A word right behind a move is its second word
	a_move_back: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && (o_dec.op == XDEC_MOVE_TO_FILE || o_dec.op == XDEC_MOVE_TO_INDEXED)
		&& o_ext_active && i_instr_valid
		|=> o_dec.op == XDEC_SECOND_WORD) else $error("back to back second word lost");
	// The second word carries the full twelve-bit address
	a_second_addr: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_SECOND_WORD
		|-> o_dec.addr == $past(i_instr[11:0])) else $error("second word address wrong");
	// Illegal only comes out while the extension was off
	a_illegal_off: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.op == XDEC_ILLEGAL
		|-> !$past(o_ext_active)) else $error("illegal decode with extension on");
	// Indexed mode is for base words only
	a_indexed_base: assert property (@(posedge i_clk) disable iff (i_reset)
		o_dec.valid && o_dec.indexed
		|-> o_dec.op == XDEC_BASE) else $error("indexed mode on an extra opcode");
endmodule

// *** verification/xdec_decoder_bench.sv ***
// Self-checking bench for the extended instruction decoder
`timescale 1ns/1ps
module xdec_decoder_bench;
	import xdec_pkg::*;
	logic        i_clk;
	logic        i_reset;
	logic        i_fuse;
	logic        i_instr_valid;
	logic [15:0] i_instr;
	xdec_dec_s   o_dec;
	logic        o_ext_active;
	int          n_errors;
	int          n_tests;
	logic [15:0] w;
	logic [15:0] cl [15] = '{16'he8c5, 16'he83f, 16'he87f, 16'he9c0, 16'he940, 16'heaff,
		16'hea00, 16'heb7f, 16'heb80, 16'h0014, 16'h0013, 16'h1000, 16'h105f, 16'h1060, 16'h1150};
	xdec_decoder uut (.i_clk(i_clk), .i_reset(i_reset), .i_fuse(i_fuse),
		.i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_dec(o_dec),
		.o_ext_active(o_ext_active));
	// Clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Expected operation class of one word
	function automatic xdec_op_e exp_op(input logic [15:0] x, input logic e);
		if (!(x[15:10] == 6'h3a || x == 16'h0014))
			return XDEC_BASE;
		if (!e)
			return XDEC_ILLEGAL;
		if (x == 16'h0014)
			return XDEC_CALL_WORKING_REGISTER;
		case (x[9:8])
			2'h0: return (x[7:6] == 2'h3) ? XDEC_PTR2_ADD_RET : XDEC_PTR_ADD;
			2'h1: return (x[7:6] == 2'h3) ? XDEC_PTR2_SUB_RET : XDEC_PTR_SUB;
			2'h2: return XDEC_PUSH_LIT;
			default: return x[7] ? XDEC_MOVE_TO_INDEXED : XDEC_MOVE_TO_FILE;
		endcase
	endfunction
	// One word offered for one cycle, then outputs sampled
	task automatic put(input logic [15:0] x);
		@(posedge i_clk);
		i_instr <= x;
		i_instr_valid <= 1'b1;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		#1;
		check("valid", o_dec.valid, 1'b1);
	endtask
	task automatic dec(input logic [15:0] x, input logic e);
		xdec_op_e op;
		op = exp_op(x, e);
		put(x);
		check("op", o_dec.op, op);
		check("fld", {o_dec.dest, o_dec.access, o_dec.addr}, {x[9:8], 4'h0, x[7:0]});
		if (op == XDEC_BASE) begin
			check("idx", o_dec.indexed, e && x[15:12] inside {[1:13]} && !x[8] && x[7:0] <= 8'h5f);
			check("blit", {o_dec.ptr_sel, o_dec.literal}, {x[7:6], x[7:0]});
		end
		if (op inside {[XDEC_PTR_ADD:XDEC_PTR2_SUB_RET]}) begin
			check("lit", o_dec.literal, {2'h0, x[5:0]});
			check("ptr", o_dec.ptr_sel, x[7:6]);
		end
		if (op == XDEC_PUSH_LIT)
			check("lit", o_dec.literal, x[7:0]);
		if (op inside {[XDEC_PTR_ADD:XDEC_PUSH_LIT]})
			check("cyc", o_dec.cycles, (op inside {[XDEC_PTR_ADD:XDEC_PTR_SUB], XDEC_PUSH_LIT}) ? 1 : 2);
		if (op inside {XDEC_MOVE_TO_FILE, XDEC_MOVE_TO_INDEXED}) begin
			w = {4'hf, 12'($urandom)};
			put(w);
			check("op2", o_dec.op, XDEC_SECOND_WORD);
			check("addr", o_dec.addr, w[11:0]);
		end
	endtask
	// Reset, then corners and random words with the fuse clear and set
	initial begin
		n_errors = 0;
		n_tests = 0;
		i_reset = 1'b1;
		i_fuse = 1'b0;
		i_instr_valid = 1'b0;
		i_instr = 16'h0000;
		void'($urandom(32'he4a61fd9));
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		check("rst", {o_dec.valid, o_ext_active}, 2'h0);
		for (int p = 0; p < 2; p++) begin
			@(posedge i_clk);
			i_fuse <= p[0];
			repeat (4) @(posedge i_clk);
			#1;
			check("ext", o_ext_active, p[0]);
			foreach (cl[k])
				dec(cl[k], p[0]);
			repeat (80) begin
				w = 16'($urandom);
				if (w[15:12] > 4'hb)
					w[15:12] = 4'hd;
				if (w[3:0] == 4'h0)
					w[15:10] = 6'h3a; // Steer some words into the extra opcodes
				if (w == 16'h0014)
					w = 16'h0015;
				dec(w, p[0]);
			end
		end
		// Move and its second word back to back
		@(posedge i_clk);
		i_instr <= 16'heb85;
		i_instr_valid <= 1'b1;
		@(posedge i_clk);
		i_instr <= 16'hf123;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		#1;
		check("b2b", o_dec.op, XDEC_SECOND_WORD);
		check("b2b_addr", o_dec.addr, 16'h0123);
		// Reset in mid-run with the fuse set, then the extension returns
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		check("rst2", {o_dec.valid, o_ext_active}, 2'h0);
		@(posedge i_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		check("ext_off", o_ext_active, 1'b0);
		repeat (2) @(posedge i_clk);
		#1;
		check("ext_on", o_ext_active, 1'b1);
		dec(16'he8c5, 1'b1);
		finish_test();
	end
endmodule
